// ---- hdl/tlbw_defs.vh ----
// Constants for the translation-entry maintenance and wait block
`ifndef TLBW_DEFS_VH
`define TLBW_DEFS_VH
// Register byte offsets
`define TLBW_OFF_CMD 12'h000
`define TLBW_OFF_STATUS 12'h004
`define TLBW_OFF_INDEX 12'h008
`define TLBW_OFF_RANDOM 12'h00C
`define TLBW_OFF_HIGH 12'h010
`define TLBW_OFF_LOW_EVEN 12'h014
`define TLBW_OFF_LOW_ODD 12'h018
`define TLBW_OFF_MASK 12'h01C
`define TLBW_OFF_PRIV 12'h020
`define TLBW_OFF_CTRL 12'h024
`define TLBW_OFF_WAKE 12'h028
// Command codes written to the command register
`define TLBW_CMD_READ 3'h1
`define TLBW_CMD_WRITE_IDX 3'h2
`define TLBW_CMD_WRITE_RND 3'h3
`define TLBW_CMD_PROBE 3'h4
`define TLBW_CMD_WAIT 3'h5
// Command register fields
`define TLBW_CMD_OP_LSB 0
`define TLBW_CMD_HINT_LSB 6
`define TLBW_CMD_HINT_MSB 24
// Entry high register fields
`define TLBW_HI_R_MSB 31
`define TLBW_HI_R_LSB 30
`define TLBW_HI_VPN_MSB 29
`define TLBW_HI_VPN_LSB 13
`define TLBW_HI_ADDRESS_SPACE_IDENTIFIER_MSB 7
`define TLBW_HI_ADDRESS_SPACE_IDENTIFIER_LSB 0
// Entry low register fields
`define TLBW_LO_PFN_MSB 25
`define TLBW_LO_PFN_LSB 6
`define TLBW_LO_C_MSB 5
`define TLBW_LO_C_LSB 3
`define TLBW_LO_D 2
`define TLBW_LO_V 1
`define TLBW_LO_G 0
// Page size mask field
`define TLBW_MASK_MSB 28
`define TLBW_MASK_LSB 13
// Privilege register fields
`define TLBW_PRIV_CU0 0
`define TLBW_PRIV_KSU_LSB 1
`define TLBW_PRIV_EXL 3
`define TLBW_PRIV_ERL 4
`define TLBW_PRIV_DM 5
// Control register fields
`define TLBW_CTRL_MASKZ 0
`define TLBW_CTRL_NOMMU 1
`define TLBW_CTRL_MCHK_EN 2
`define TLBW_CTRL_NONEN_WAKE 3
// Status register fields
`define TLBW_ST_CPU 0
`define TLBW_ST_RI 1
`define TLBW_ST_MCHK 2
`define TLBW_ST_WAITING 3
`define TLBW_ST_INT 4
`define TLBW_ST_NMI 5
`define TLBW_ST_RST 6
`define TLBW_ST_NONEN 7
// Entry geometry
`define TLBW_ENTRIES 16
`define TLBW_IDX_W 4
`define TLBW_ENTRY_W 94
// Entry word field positions, page halves at the bottom
`define TLBW_E_CDV0_LSB 0
`define TLBW_E_EVEN_FRAME_NUMBER_LSB 5
`define TLBW_E_CDV1_LSB 25
`define TLBW_E_ODD_FRAME_NUMBER_LSB 30
`define TLBW_E_G 50
`define TLBW_E_ADDRESS_SPACE_IDENTIFIER_LSB 51
`define TLBW_E_VPN_LSB 59
`define TLBW_E_R_LSB 76
`define TLBW_E_MASK_LSB 78
// Reset values
`define TLBW_RANDOM_RST 4'hF
`endif

// ---- hdl/tlbw_entry_array.v ----
// Translation entry storage, one flip-flop word per entry
`timescale 1ns/10ps
`include "tlbw_defs.vh"
module tlbw_entry_array (
	input wire pclk,
	input wire presetn,
	input wire wr_en,
	input wire [`TLBW_IDX_W-1:0] wr_idx,
	input wire [`TLBW_ENTRY_W-1:0] wr_data,
	input wire [`TLBW_IDX_W-1:0] rd_idx,
	output wire [`TLBW_ENTRY_W-1:0] rd_data,
	output wire [`TLBW_ENTRIES*`TLBW_ENTRY_W-1:0] all_data
);
	genvar gi;
	// One word per entry, written only when addressed
	generate
		for (gi = 0; gi < `TLBW_ENTRIES; gi = gi + 1) begin : g_ent
			reg [`TLBW_ENTRY_W-1:0] ent_reg;
			always @(posedge pclk or negedge presetn) begin
				if (!presetn)
					ent_reg <= {`TLBW_ENTRY_W{1'b0}};
				else if (wr_en && wr_idx == gi)
					ent_reg <= wr_data;
			end
			assign all_data[gi*`TLBW_ENTRY_W +: `TLBW_ENTRY_W] = ent_reg;
		end
	endgenerate
	assign rd_data = all_data[rd_idx*`TLBW_ENTRY_W +: `TLBW_ENTRY_W];
endmodule

// ---- hdl/tlbw_top.v ----
// Translation entry read/write/probe and wait-for-event control over APB
// Contract
// - Table read loads high, both low and mask registers from indexed entry.
// - Read may zero page pair bits under one bits of the mask.
// - Read may zero both frame numbers under one bits of the mask.
// - Read copies the single global bit into both low registers.
// - Indexed write overwrites the indexed entry from the staging registers.
// - Random write overwrites the entry chosen by the random register.
// - Write stores mask, region, space id, page pair, and per-page bits.
// - Write may clear page pair bits under one bits of the mask.
// - Write may clear both frame numbers under one bits of the mask.
// - Write sets the global bit to AND of both low global bits.
// - Executes only when privileged; otherwise coprocessor-unusable for unit 0.
// - Without a translation unit, raise reserved-instruction instead.
// - Machine-check on a shutdown condition during read or write.
// - Wait hint bits 24..6 pass to low-power control; zero is default.
// - Wait stalls the pipeline in low power until an event restarts it.
// - Enabled interrupt ending wait is taken; return points after the wait.
// - Reset or unmasked NMI during wait restarts and takes its exception.
// - Probe loads index with matching entry, or sets its top bit.
`timescale 1ns/10ps
`include "tlbw_defs.vh"
module tlbw_top (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire irq_enabled_in,
	input wire irq_pending_in,
	input wire nmi_in,
	input wire soft_reset_in,
	input wire shutdown_in,
	output reg pipeline_stall,
	output reg low_power,
	output reg [18:0] wait_hint,
	output reg take_interrupt,
	output reg take_nmi,
	output reg take_reset
);
	localparam ST_IDLE = 1'b0;
	localparam ST_WAIT = 1'b1;
	// Field widths of the staging registers
	localparam LO_W = 26;
	localparam MASK_W = 16;
	localparam VPN_W = 17;
	localparam PFN_W = 20;

	// Staging, control and status state
	reg state_reg;
	reg [31:0] index_reg;
	reg [`TLBW_IDX_W-1:0] random_reg;
	reg [31:0] entry_high_reg;
	reg [LO_W-1:0] entry_low_even_reg;
	reg [LO_W-1:0] entry_low_odd_reg;
	reg [MASK_W-1:0] page_size_mask_reg;
	reg [5:0] priv_reg;
	reg [3:0] ctrl_reg;
	reg [7:0] status_reg;
	reg [7:0] status_next;
	reg [31:0] ret_addr_reg;
	reg [31:0] pc_hint_reg;
	reg [2:0] sync_a_reg;
	reg [2:0] sync_b_reg;
	reg shut_a_reg;
	reg shut_b_reg;

	// Entry layout: mask|region|vpn|address_space_identifier|g|odd_frame_number|c1 d1 v1|even_frame_number|c0 d0 v0
	wire [`TLBW_ENTRY_W-1:0] wr_data;
	wire [`TLBW_ENTRY_W-1:0] rd_data;
	wire [`TLBW_ENTRIES*`TLBW_ENTRY_W-1:0] all_data;
	wire [`TLBW_IDX_W-1:0] wr_idx;
	reg wr_en;

	// Zero wait state, so pready need not gate the access strobe
	wire access = psel && penable;
	wire wr_acc = access && pwrite;
	wire cmd_wr = wr_acc && paddr == `TLBW_OFF_CMD;
	wire [2:0] cmd_op = pwdata[`TLBW_CMD_OP_LSB +: 3];
	wire maskz = ctrl_reg[`TLBW_CTRL_MASKZ];

	// Privilege check for every maintenance and wait command
	wire allowed = priv_reg[`TLBW_PRIV_CU0]
		|| priv_reg[`TLBW_PRIV_KSU_LSB +: 2] == 2'b00
		|| priv_reg[`TLBW_PRIV_DM]
		|| priv_reg[`TLBW_PRIV_EXL]
		|| priv_reg[`TLBW_PRIV_ERL];
	wire is_tlb_op = cmd_op == `TLBW_CMD_READ || cmd_op == `TLBW_CMD_WRITE_IDX
		|| cmd_op == `TLBW_CMD_WRITE_RND || cmd_op == `TLBW_CMD_PROBE;
	// Without a translation unit the table ops are refused
	wire go = cmd_wr && allowed && !(is_tlb_op && ctrl_reg[`TLBW_CTRL_NOMMU]);
	// Probe never machine-checks; only reads and writes do
	wire mchk = go && is_tlb_op && cmd_op != `TLBW_CMD_PROBE
		&& ctrl_reg[`TLBW_CTRL_MCHK_EN] && shut_b_reg;

	// Staging fields, optionally masked before storing
	wire [MASK_W-1:0] pm = page_size_mask_reg;
	wire [VPN_W-1:0] hi_vpn = entry_high_reg[`TLBW_HI_VPN_MSB:`TLBW_HI_VPN_LSB];
	wire [7:0] hi_address_space_identifier = entry_high_reg[`TLBW_HI_ADDRESS_SPACE_IDENTIFIER_MSB:`TLBW_HI_ADDRESS_SPACE_IDENTIFIER_LSB];
	wire [VPN_W-1:0] vpn_st = maskz ? hi_vpn & ~{1'b0, pm} : hi_vpn;
	wire [PFN_W-1:0] even_frame_number = entry_low_even_reg[`TLBW_LO_PFN_MSB:`TLBW_LO_PFN_LSB];
	wire [PFN_W-1:0] odd_frame_number = entry_low_odd_reg[`TLBW_LO_PFN_MSB:`TLBW_LO_PFN_LSB];
	wire [PFN_W-1:0] even_frame_number_st = maskz ? even_frame_number & ~{4'h0, pm} : even_frame_number;
	wire [PFN_W-1:0] odd_frame_number_st = maskz ? odd_frame_number & ~{4'h0, pm} : odd_frame_number;
	wire g_st = entry_low_even_reg[`TLBW_LO_G] & entry_low_odd_reg[`TLBW_LO_G];
	assign wr_data = {pm, entry_high_reg[`TLBW_HI_R_MSB:`TLBW_HI_R_LSB], vpn_st,
		entry_high_reg[`TLBW_HI_ADDRESS_SPACE_IDENTIFIER_MSB:`TLBW_HI_ADDRESS_SPACE_IDENTIFIER_LSB], g_st,
		odd_frame_number_st, entry_low_odd_reg[`TLBW_LO_C_MSB:`TLBW_LO_V],
		even_frame_number_st, entry_low_even_reg[`TLBW_LO_C_MSB:`TLBW_LO_V]};
	// Random write picks the random register, otherwise the index
	assign wr_idx = cmd_op == `TLBW_CMD_WRITE_RND ? random_reg
		: index_reg[`TLBW_IDX_W-1:0];

	// Write strobe, suppressed on machine check
	always @* begin
		wr_en = go && !mchk && (cmd_op == `TLBW_CMD_WRITE_IDX
			|| cmd_op == `TLBW_CMD_WRITE_RND);
	end

	// Index above the array is truncated; software must keep it in range
	tlbw_entry_array u_array (
		.pclk(pclk),
		.presetn(presetn),
		.wr_en(wr_en),
		.wr_idx(wr_idx),
		.wr_data(wr_data),
		.rd_idx(index_reg[`TLBW_IDX_W-1:0]),
		.rd_data(rd_data),
		.all_data(all_data)
	);

	// Read-side field split of the selected entry
	wire [MASK_W-1:0] rd_mask = rd_data[`TLBW_E_MASK_LSB +: MASK_W];
	wire [1:0] rd_r = rd_data[`TLBW_E_R_LSB +: 2];
	wire [VPN_W-1:0] rd_vpn = rd_data[`TLBW_E_VPN_LSB +: VPN_W];
	wire [7:0] rd_address_space_identifier = rd_data[`TLBW_E_ADDRESS_SPACE_IDENTIFIER_LSB +: 8];
	wire rd_g = rd_data[`TLBW_E_G];
	wire [PFN_W-1:0] rd_odd_frame_number = rd_data[`TLBW_E_ODD_FRAME_NUMBER_LSB +: PFN_W];
	// Cache attribute, dirty and valid travel together per page
	wire [4:0] rd_cdv1 = rd_data[`TLBW_E_CDV1_LSB +: 5];
	wire [PFN_W-1:0] rd_even_frame_number = rd_data[`TLBW_E_EVEN_FRAME_NUMBER_LSB +: PFN_W];
	wire [4:0] rd_cdv0 = rd_data[`TLBW_E_CDV0_LSB +: 5];
	wire [VPN_W-1:0] rd_vpn_m = maskz ? rd_vpn & ~{1'b0, rd_mask} : rd_vpn;
	wire [PFN_W-1:0] rd_odd_frame_number_m = maskz ? rd_odd_frame_number & ~{4'h0, rd_mask} : rd_odd_frame_number;
	wire [PFN_W-1:0] rd_even_frame_number_m = maskz ? rd_even_frame_number & ~{4'h0, rd_mask} : rd_even_frame_number;

	// Probe: compare every entry against the high register
	reg probe_hit;
	reg [`TLBW_IDX_W-1:0] probe_idx;
	reg [`TLBW_ENTRY_W-1:0] pe;
	reg [MASK_W-1:0] pm_k;
	integer k;
	always @* begin
		probe_hit = 1'b0;
		probe_idx = {`TLBW_IDX_W{1'b0}};
		pe = {`TLBW_ENTRY_W{1'b0}};
		pm_k = {MASK_W{1'b0}};
		// Later entries win; duplicate matches are a software fault
		for (k = 0; k < `TLBW_ENTRIES; k = k + 1) begin
			pe = all_data[k*`TLBW_ENTRY_W +: `TLBW_ENTRY_W];
			pm_k = pe[`TLBW_E_MASK_LSB +: MASK_W];
			if (pe[`TLBW_E_R_LSB +: 2] == entry_high_reg[`TLBW_HI_R_MSB:`TLBW_HI_R_LSB]
				&& (pe[`TLBW_E_VPN_LSB +: VPN_W] & ~{1'b0, pm_k}) == (hi_vpn & ~{1'b0, pm_k})
				&& (pe[`TLBW_E_G] || pe[`TLBW_E_ADDRESS_SPACE_IDENTIFIER_LSB +: 8] == hi_address_space_identifier)) begin
				probe_hit = 1'b1;
				probe_idx = k[`TLBW_IDX_W-1:0];
			end
		end
	end

	// Event inputs come from outside and pass two flip-flops
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_a_reg <= 3'h0;
			sync_b_reg <= 3'h0;
			shut_a_reg <= 1'b0;
			shut_b_reg <= 1'b0;
		end else begin
			sync_a_reg <= {soft_reset_in, nmi_in, irq_pending_in};
			sync_b_reg <= sync_a_reg;
			shut_a_reg <= shutdown_in;
			shut_b_reg <= shut_a_reg;
		end
	end
	wire ev_irq = sync_b_reg[0];
	wire ev_nmi = sync_b_reg[1];
	wire ev_rst = sync_b_reg[2];
	// Enable is a same-clock level and skips the synchroniser
	wire irq_en = irq_enabled_in;
	wire wake_en = ev_irq && irq_en;
	wire wake_nonen = ev_irq && !irq_en && ctrl_reg[`TLBW_CTRL_NONEN_WAKE];
	wire in_wait = state_reg == ST_WAIT;
	wire wake = in_wait && (ev_rst || ev_nmi || wake_en || wake_nonen);

	// Sticky status, except the live waiting bit: hardware set wins over a software clear
	wire st_wr = wr_acc && paddr == `TLBW_OFF_STATUS;
	always @* begin
		status_next = status_reg;
		// Software clear first, so a same-cycle event still lands
		if (st_wr)
			status_next = status_reg & ~pwdata[7:0];
		status_next[`TLBW_ST_WAITING] = in_wait && !wake;
		if (cmd_wr && !allowed)
			status_next[`TLBW_ST_CPU] = 1'b1;
		if (cmd_wr && allowed && is_tlb_op && ctrl_reg[`TLBW_CTRL_NOMMU])
			status_next[`TLBW_ST_RI] = 1'b1;
		if (mchk)
			status_next[`TLBW_ST_MCHK] = 1'b1;
		// Cause priority matches the wake pulse priority
		if (wake && ev_rst)
			status_next[`TLBW_ST_RST] = 1'b1;
		else if (wake && ev_nmi)
			status_next[`TLBW_ST_NMI] = 1'b1;
		else if (wake && wake_en)
			status_next[`TLBW_ST_INT] = 1'b1;
		else if (wake && wake_nonen)
			status_next[`TLBW_ST_NONEN] = 1'b1;
	end

	// Register writes and command execution
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			index_reg <= 32'h00000000;
			random_reg <= `TLBW_RANDOM_RST;
			entry_high_reg <= 32'h00000000;
			entry_low_even_reg <= 26'h0000000;
			entry_low_odd_reg <= 26'h0000000;
			page_size_mask_reg <= 16'h0000;
			priv_reg <= 6'h00;
			ctrl_reg <= 4'h0;
			status_reg <= 8'h00;
			pc_hint_reg <= 32'h00000000;
			ret_addr_reg <= 32'h00000000;
		end else begin
			status_reg <= status_next;
			// Random decrements each cycle, wraps to the top entry
			random_reg <= random_reg - 4'h1;
			if (wr_acc) begin
				case (paddr)
					`TLBW_OFF_INDEX: index_reg <= pwdata;
					`TLBW_OFF_RANDOM: random_reg <= pwdata[`TLBW_IDX_W-1:0];
					`TLBW_OFF_HIGH: entry_high_reg <= pwdata;
					`TLBW_OFF_LOW_EVEN: entry_low_even_reg <= pwdata[LO_W-1:0];
					`TLBW_OFF_LOW_ODD: entry_low_odd_reg <= pwdata[LO_W-1:0];
					`TLBW_OFF_MASK: page_size_mask_reg <= pwdata[`TLBW_MASK_MSB:`TLBW_MASK_LSB];
					`TLBW_OFF_PRIV: priv_reg <= pwdata[5:0];
					`TLBW_OFF_CTRL: ctrl_reg <= pwdata[3:0];
					`TLBW_OFF_WAKE: pc_hint_reg <= pwdata;
					default: ;
				endcase
			end
			// Read loads all four staging registers in one step
			if (go && !mchk && cmd_op == `TLBW_CMD_READ) begin
				page_size_mask_reg <= rd_mask;
				entry_high_reg <= {rd_r, rd_vpn_m, 5'h00, rd_address_space_identifier};
				entry_low_odd_reg <= {rd_odd_frame_number_m, rd_cdv1, rd_g};
				entry_low_even_reg <= {rd_even_frame_number_m, rd_cdv0, rd_g};
			end
			if (go && cmd_op == `TLBW_CMD_PROBE)
				index_reg <= {!probe_hit, 27'h0000000, probe_idx};
			// Return address of the next instruction after the wait
			if (go && cmd_op == `TLBW_CMD_WAIT)
				ret_addr_reg <= pc_hint_reg + 32'h00000004;
		end
	end

	// Wait state machine and pipeline-facing outputs
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_IDLE;
			pipeline_stall <= 1'b0;
			low_power <= 1'b0;
			wait_hint <= 19'h00000;
			take_interrupt <= 1'b0;
			take_nmi <= 1'b0;
			take_reset <= 1'b0;
		end else begin
			take_interrupt <= 1'b0;
			take_nmi <= 1'b0;
			take_reset <= 1'b0;
			// Wake pulses default low, so each lasts one cycle
			case (state_reg)
				ST_IDLE: begin
					if (go && cmd_op == `TLBW_CMD_WAIT) begin
						state_reg <= ST_WAIT;
						pipeline_stall <= 1'b1;
						low_power <= 1'b1;
						// Zero hint is the default low-power mode
						wait_hint <= pwdata[`TLBW_CMD_HINT_MSB:`TLBW_CMD_HINT_LSB];
					end
				end
				ST_WAIT: begin
					// Reset beats nmi, nmi beats an interrupt
					if (wake) begin
						state_reg <= ST_IDLE;
						pipeline_stall <= 1'b0;
						low_power <= 1'b0;
						wait_hint <= 19'h00000;
						take_reset <= ev_rst;
						take_nmi <= !ev_rst && ev_nmi;
						take_interrupt <= !ev_rst && !ev_nmi && wake_en;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// APB slave: zero wait state, error on unmapped address
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			// Read data captured in setup so it stands in the access cycle
			if (psel && !penable) begin
				prdata <= 32'h00000000;
				case (paddr)
					`TLBW_OFF_CMD: prdata <= {8'h00, wait_hint, 5'h00};
					`TLBW_OFF_STATUS: prdata <= {24'h000000, status_next};
					`TLBW_OFF_INDEX: prdata <= index_reg;
					`TLBW_OFF_RANDOM: prdata <= {28'h0000000, random_reg};
					`TLBW_OFF_HIGH: prdata <= entry_high_reg;
					`TLBW_OFF_LOW_EVEN: prdata <= {6'h00, entry_low_even_reg};
					`TLBW_OFF_LOW_ODD: prdata <= {6'h00, entry_low_odd_reg};
					`TLBW_OFF_MASK: prdata <= {3'h0, page_size_mask_reg, 13'h0000};
					`TLBW_OFF_PRIV: prdata <= {26'h0000000, priv_reg};
					`TLBW_OFF_CTRL: prdata <= {28'h0000000, ctrl_reg};
					`TLBW_OFF_WAKE: prdata <= ret_addr_reg;
					default: pslverr <= 1'b1;
				endcase
			end
		end
	end
endmodule

// ---- verification/tlbw_properties.sv ----
// Checker of wait, wake and hint relations at the block ports
`timescale 1ns/10ps
`include "tlbw_defs.vh"
module tlbw_properties (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire pready,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire irq_enabled_in,
	input wire irq_pending_in,
	input wire nmi_in,
	input wire soft_reset_in,
	input wire pipeline_stall,
	input wire low_power,
	input wire [18:0] wait_hint,
	input wire take_interrupt,
	input wire take_nmi,
	input wire take_reset
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Decoded wait command and any wake pulse
	wire wait_cmd = psel && penable && pready && pwrite && paddr == `TLBW_OFF_CMD
		&& pwdata[2:0] == `TLBW_CMD_WAIT;
	wire any_take = take_interrupt || take_nmi || take_reset;
	property p_power; low_power == pipeline_stall; endproperty
	a_power: assert property (p_power) else $error("stall and low power differ");
	property p_cause; $rose(pipeline_stall) |-> $past(wait_cmd); endproperty
	a_cause: assert property (p_cause) else $error("stall without wait command");
	property p_hint; pipeline_stall && $past(pipeline_stall) |-> $stable(wait_hint); endproperty
	a_hint: assert property (p_hint) else $error("hint moved while waiting");
	property p_end; any_take |-> $fell(pipeline_stall); endproperty
	a_end: assert property (p_end) else $error("wake pulse outside wait end");
	property p_one; $onehot0({take_interrupt, take_nmi, take_reset}); endproperty
	a_one: assert property (p_one) else $error("more than one wake pulse");
	property p_pulse; any_take |=> !any_take; endproperty
	a_pulse: assert property (p_pulse) else $error("wake pulse too long");
	property p_nmi; pipeline_stall && nmi_in && !soft_reset_in |-> ##[1:4] take_nmi; endproperty
	a_nmi: assert property (p_nmi) else $error("nmi did not wake");
	property p_rst; pipeline_stall && soft_reset_in |-> ##[1:4] take_reset; endproperty
	a_rst: assert property (p_rst) else $error("reset did not wake");
	property p_int;
		pipeline_stall && irq_pending_in && irq_enabled_in && !nmi_in && !soft_reset_in
			|-> ##[1:4] take_interrupt;
	endproperty
	a_int: assert property (p_int) else $error("interrupt did not wake");
	c_int: cover property (take_interrupt);
	c_nmi: cover property (take_nmi);
	c_rst: cover property (take_reset);
endmodule
bind tlbw_top tlbw_properties u_tlbw_properties (.pclk, .presetn, .psel, .penable, .pwrite,
	.pready, .paddr, .pwdata, .irq_enabled_in, .irq_pending_in, .nmi_in, .soft_reset_in,
	.pipeline_stall, .low_power, .wait_hint, .take_interrupt, .take_nmi, .take_reset);

// ---- verification/tlbw_pipe_model.sv ----
// Pipeline-side model raising wake events and the shutdown flag
`timescale 1ns/10ps
module tlbw_pipe_model (
	input wire pclk,
	input wire presetn,
	input wire [2:0] ev_kind,
	input wire ev_go,
	input wire shut_req,
	input wire pipeline_stall,
	output reg irq_enabled_in,
	output reg irq_pending_in,
	output reg nmi_in,
	output reg soft_reset_in,
	output reg shutdown_in
);
	// Event held until the stall drops, as a real request line would be
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{irq_enabled_in, irq_pending_in, nmi_in, soft_reset_in} <= 4'h0;
			shutdown_in <= 1'b0;
		end else begin
			shutdown_in <= shut_req;
			if (ev_go) begin
				irq_pending_in <= ev_kind == 3'h1 || ev_kind == 3'h2;
				irq_enabled_in <= ev_kind == 3'h1;
				nmi_in <= ev_kind == 3'h3;
				soft_reset_in <= ev_kind == 3'h4;
			end else if (!pipeline_stall) begin
				{irq_enabled_in, irq_pending_in, nmi_in, soft_reset_in} <= 4'h0;
			end
		end
	end
endmodule

// ---- verification/tb_top.sv ----
// Self-checking bench for the translation entry and wait block
`timescale 1ns/10ps
`include "tlbw_defs.vh"
module tb_top;
	reg pclk = 1'b0;
	reg presetn = 1'b0;
	reg psel = 1'b0;
	reg penable = 1'b0;
	reg pwrite = 1'b0;
	reg [11:0] paddr = 12'h000;
	reg [31:0] pwdata = 32'h00000000;
	reg [2:0] ev_kind = 3'h0;
	reg ev_go = 1'b0;
	reg shut_req = 1'b0;
	wire [31:0] prdata;
	wire pready, pslverr, irq_e, irq_p, nmi, srst, shut, stall, lowp, t_int, t_nmi, t_rst;
	wire [18:0] hint;
	integer num_errors = 0;
	integer n_tests = 0;
	integer i, j, hits;
	reg [31:0] rd, hi;
	reg err;
	reg [31:0] ex [0:3];
	always #5 pclk = ~pclk;
	tlbw_top u_tlbw_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .irq_enabled_in(irq_e), .irq_pending_in(irq_p), .nmi_in(nmi),
		.soft_reset_in(srst), .shutdown_in(shut), .pipeline_stall(stall), .low_power(lowp),
		.wait_hint(hint), .take_interrupt(t_int), .take_nmi(t_nmi), .take_reset(t_rst));
	tlbw_pipe_model u_tlbw_pipe_model (.pclk, .presetn, .ev_kind, .ev_go, .shut_req,
		.pipeline_stall(stall), .irq_enabled_in(irq_e), .irq_pending_in(irq_p),
		.nmi_in(nmi), .soft_reset_in(srst), .shutdown_in(shut));
	task check(input string nm, input [31:0] seen, input [31:0] exp);
		begin
			n_tests++;
			if (seen !== exp) begin
				num_errors++;
				$display("ERROR %s expected %h seen %h", nm, exp, seen);
			end
		end
	endtask
	// One APB transfer; request held until pready is sampled high
	task apb(input w, input [11:0] a, input [31:0] d);
		begin
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'b1;
			// No cycle count assumed; only the watchdog ends a hung wait
			do begin
				@(posedge pclk);
			end while (pready !== 1'b1);
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge pclk);
		end
	endtask
	task wr(input [11:0] a, input [31:0] d);
		apb(1'b1, a, d);
	endtask
	task rdr(input [11:0] a);
		apb(1'b0, a, 32'h00000000);
	endtask
	task cmd(input [2:0] op, input [18:0] h);
		apb(1'b1, `TLBW_OFF_CMD, {7'h00, h, 3'h0, op});
	endtask
	task wrap_up;
		begin
			if (num_errors == 0 && n_tests > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask
	// Watchdog far beyond the few hundred cycles the sequence needs
	initial begin
		repeat (20000) @(posedge pclk);
		num_errors++;
		wrap_up;
	end
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		wr(`TLBW_OFF_PRIV, 32'h00000001);
		// Clear all entries, then one random write must land on exactly one
		for (i = 0; i < 16; i++) begin
			wr(`TLBW_OFF_INDEX, i);
			cmd(`TLBW_CMD_WRITE_IDX, 19'h00000);
		end
		wr(`TLBW_OFF_HIGH, 32'h4AAAA011);
		cmd(`TLBW_CMD_WRITE_RND, 19'h00000);
		hits = 0;
		for (i = 0; i < 16; i++) begin
			wr(`TLBW_OFF_INDEX, i);
			cmd(`TLBW_CMD_READ, 19'h00000);
			rdr(`TLBW_OFF_HIGH);
			if (rd === 32'h4AAAA011) hits++;
		end
		check("random_hits", hits, 1);
		// Write then read back, global bit from the AND of both halves
		for (i = 0; i < 2; i++) begin
			hi = i ? 32'h80012033 : 32'hC0FFE0A5;
			ex[0] = hi;
			ex[1] = 32'h03FFFFFE | i;
			ex[2] = 32'h0155554E | i;
			ex[3] = i ? 32'h1FFFE000 : 32'h00000000;
			for (j = 0; j < 4; j++) wr(`TLBW_OFF_HIGH + 4 * j, j == 1 ? 32'h03FFFFFF : ex[j]);
			wr(`TLBW_OFF_INDEX, i ? 15 : 3);
			cmd(`TLBW_CMD_WRITE_IDX, 19'h00000);
			for (j = 0; j < 4; j++) wr(`TLBW_OFF_HIGH + 4 * j, 32'h00000000);
			cmd(`TLBW_CMD_READ, 19'h00000);
			for (j = 0; j < 4; j++) begin
				rdr(`TLBW_OFF_HIGH + 4 * j);
				check("staging", rd, ex[j]);
			end
		end
		wr(`TLBW_OFF_HIGH, 32'hC0FFE0A5);
		cmd(`TLBW_CMD_PROBE, 19'h00000);
		rdr(`TLBW_OFF_INDEX);
		check("probe_hit", rd, 32'h00000003);
		wr(`TLBW_OFF_HIGH, 32'h40002022);
		cmd(`TLBW_CMD_PROBE, 19'h00000);
		rdr(`TLBW_OFF_INDEX);
		check("probe_miss", rd[31], 1);
		wr(`TLBW_OFF_INDEX, 0);
		// Only the first privilege setting lacks every enabling condition
		for (i = 0; i < 6; i++) begin
			wr(`TLBW_OFF_STATUS, 32'h000000FF);
			wr(`TLBW_OFF_PRIV, i == 0 ? 2 : i == 1 ? 3 : i == 2 ? 0 : 2 + 8 * (1 << (i - 3)));
			cmd(`TLBW_CMD_READ, 19'h00000);
			rdr(`TLBW_OFF_STATUS);
			check("cpu_unusable", rd[0], i == 0);
		end
		wr(`TLBW_OFF_CTRL, 32'h00000002);
		cmd(`TLBW_CMD_READ, 19'h00000);
		rdr(`TLBW_OFF_STATUS);
		check("reserved_instr", rd[1], 1);
		wr(`TLBW_OFF_CTRL, 32'h00000004);
		shut_req <= 1'b1;
		repeat (4) @(posedge pclk);
		cmd(`TLBW_CMD_WRITE_IDX, 19'h00000);
		rdr(`TLBW_OFF_STATUS);
		check("machine_check", rd[2], 1);
		shut_req <= 1'b0;
		rdr(12'h0FC);
		check("unmapped_err", err, 1);
		check("unmapped_data", rd, 32'h00000000);
		// Wake by enabled interrupt, nmi, reset, then non-enabled interrupt
		for (i = 0; i < 4; i++) begin
			wr(`TLBW_OFF_CTRL, i == 3 ? 8 : 0);
			wr(`TLBW_OFF_STATUS, 32'h000000FF);
			wr(`TLBW_OFF_WAKE, 32'h00001000);
			cmd(`TLBW_CMD_WAIT, i ? 19'h7FFFF : 19'h00000);
			check("stall", {stall, lowp}, 2'b11);
			check("hint", hint, i ? 19'h7FFFF : 19'h00000);
			ev_kind <= i == 3 ? 3'h2 : i + 1 + (i > 0);
			ev_go <= 1'b1;
			@(posedge pclk);
			ev_go <= 1'b0;
			j = 0;
			while (stall !== 1'b0 && j < 20) begin
				@(posedge pclk);
				j++;
			end
			check("take", {t_int, t_nmi, t_rst}, i < 3 ? 3'b100 >> i : 3'b000);
			rdr(`TLBW_OFF_STATUS);
			check("cause", rd[4 + i], 1);
			rdr(`TLBW_OFF_WAKE);
			check("return_addr", rd, 32'h00001004);
		end
		// Mask zeroing on the read side, then on the write side
		for (i = 0; i < 2; i++) begin
			wr(`TLBW_OFF_CTRL, i);
			wr(`TLBW_OFF_HIGH, 32'hFFFFE0A5);
			wr(`TLBW_OFF_LOW_EVEN, 32'h03FFFFFF);
			wr(`TLBW_OFF_LOW_ODD, 32'h03FFFFFF);
			wr(`TLBW_OFF_MASK, 32'h00006000);
			wr(`TLBW_OFF_INDEX, 5 + i);
			cmd(`TLBW_CMD_WRITE_IDX, 19'h00000);
			wr(`TLBW_OFF_CTRL, 1 - i);
			cmd(`TLBW_CMD_READ, 19'h00000);
			rdr(`TLBW_OFF_HIGH);
			check("masked_high", rd, 32'hFFFF80A5);
			rdr(`TLBW_OFF_LOW_EVEN);
			check("masked_even", rd, 32'h03FFFF3F);
			rdr(`TLBW_OFF_LOW_ODD);
			check("masked_odd", rd, 32'h03FFFF3F);
		end
		wrap_up;
	end
endmodule
